// [rtl/etxpc_consts.vh]
// Constants for the transmit path control block
`ifndef ETXPC_CONSTS_VH
`define ETXPC_CONSTS_VH

// Register byte addresses
`define ETXPC_ADDR_CTRL    8'h00
`define ETXPC_ADDR_STATUS  8'h04

// Control register field positions and reset value
`define ETXPC_CTRL_ENABLE  0
`define ETXPC_CTRL_RFI     1
`define ETXPC_CTRL_LFI     2
`define ETXPC_CTRL_IDLE    3
`define ETXPC_CTRL_FCS     4
`define ETXPC_CTRL_RATE    5
`define ETXPC_CTRL_RESET   6'h00

// Link characters; control ones go out with the control flag high
`define ETXPC_CH_IDLE      8'h07
`define ETXPC_CH_START     8'hFB
`define ETXPC_CH_TERM      8'hFD
`define ETXPC_CH_ERROR     8'hFE
`define ETXPC_CH_SEQ       8'h9C
`define ETXPC_CH_ZERO      8'h00
`define ETXPC_CH_LF        8'h01
`define ETXPC_CH_RF        8'h02

// Ordered set columns for the fault code and sequence char; last FCS byte index
`define ETXPC_COL_CODE     2'h3
`define ETXPC_COL_SEQ      2'h0
`define ETXPC_FCS_LAST     2'h3

// CRC-32 constants
`define ETXPC_CRC_POLY     32'hEDB88320
`define ETXPC_CRC_INIT     32'hFFFFFFFF

`endif

// [rtl/etxpc_crc32.v]
// Byte-serial CRC-32 engine for the frame check sequence
`timescale 1ns/1ns
`include "etxpc_consts.vh"

module etxpc_crc32 (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // Control and data
  input  wire        crcInit,
  input  wire        crcUpdate,
  input  wire [7:0]  crcByte,
  // Running remainder, registered
  output reg  [31:0] crcValue
);

  reg [31:0] crcNext;   // Remainder after folding one byte
  integer    bitIdx;    // Bit loop index

  // Reflected CRC, one bit per loop step, LSB of byte first
  always @* begin
    crcNext = crcValue;
    for (bitIdx = 0; bitIdx < 8; bitIdx = bitIdx + 1) begin
      if (crcNext[0] ^ crcByte[bitIdx]) begin
        crcNext = (crcNext >> 1) ^ `ETXPC_CRC_POLY;
      end else begin
        crcNext = crcNext >> 1;
      end
    end
  end

  // Init wins over update so a frame never inherits stale state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crcValue <= `ETXPC_CRC_INIT;
    end else if (ce) begin
      if (crcInit) begin
        crcValue <= `ETXPC_CRC_INIT;
      end else if (crcUpdate) begin
        crcValue <= crcNext;
      end
    end
  end

endmodule

// [rtl/etxpc_tx_ctrl.v]
// Transmit path control: rate, enable, fault forcing and FCS insertion
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "etxpc_consts.vh"

module etxpc_tx_ctrl (
  // Clock, reset, clock enable
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // Register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  // Packet byte stream in
  input  wire [7:0] inData,
  input  wire       inValid,
  input  wire       inLast,
  output reg        inReady,
  // Link character stream out
  output reg  [7:0] txData,
  output reg        txCtrl,
  // Speed selection
  output reg        rateSel40g
);

  // Transmit states
  localparam [2:0] ST_IDLE  = 3'h0;  // Between packets
  localparam [2:0] ST_START = 3'h1;  // Start character
  localparam [2:0] ST_DATA  = 3'h2;  // Payload bytes
  localparam [2:0] ST_FCS   = 3'h3;  // Four FCS bytes
  localparam [2:0] ST_TERM  = 3'h4;  // Terminate character
  localparam [2:0] ST_DROP  = 3'h5;  // Discard rest of preempted frame

  reg  [5:0]  ctrl_q;      // Control register
  reg  [2:0]  state_q;     // Transmit state
  reg  [2:0]  state_d;
  reg  [1:0]  col_q;       // Ordered set column
  reg  [1:0]  fcsCnt_q;    // FCS byte index
  reg  [1:0]  fcsCnt_d;
  reg         fcsOn_q;     // FCS setting latched at frame start
  reg         fcsOn_d;
  reg  [7:0]  txData_d;
  reg         txCtrl_d;
  reg         inReady_d;
  wire [31:0] crcValue;    // Running remainder
  wire        accept;      // Byte taken this cycle
  wire        forceLf;     // Local fault request
  wire        forceRf;     // Remote fault request
  wire        forceIdle;   // Idle request
  wire        forced;      // Any forcing active
  wire [31:0] fcsWord;     // Complemented remainder

  assign accept    = inValid & inReady;
  assign forceLf   = ctrl_q[`ETXPC_CTRL_LFI];
  assign forceRf   = ctrl_q[`ETXPC_CTRL_RFI];
  assign forceIdle = ctrl_q[`ETXPC_CTRL_IDLE];
  assign forced    = forceLf | forceRf | forceIdle;
  assign fcsWord   = ~crcValue;

  // CRC engine, restarted at each start character
  etxpc_crc32 etxpc_crc32_inst (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .crcInit   (state_q == ST_START),
    .crcUpdate (accept && state_q == ST_DATA),
    .crcByte   (inData),
    .crcValue  (crcValue)
  );

  // Register writes; rate is static, changing it needs matching clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= `ETXPC_CTRL_RESET;
      rateSel40g <= 1'b0;
    end else if (ce) begin
      if (regWr && regAddr == `ETXPC_ADDR_CTRL) begin
        ctrl_q <= regWrData[5:0];
      end
      rateSel40g <= ctrl_q[`ETXPC_CTRL_RATE];
    end
  end

  // Register reads; data stand in the cycle after the strobe only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (ce) begin
      if (regRd && regAddr == `ETXPC_ADDR_CTRL) begin
        regRdData <= {2'h0, ctrl_q};
      end else if (regRd && regAddr == `ETXPC_ADDR_STATUS) begin
        regRdData <= {3'h0, fcsOn_q, forced, state_q};
      end else begin
        regRdData <= 8'h00;  // Unmapped or no read
      end
    end
  end

  // Column counter runs free so ordered sets stay aligned
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      col_q <= 2'h0;
    end else if (ce) begin
      col_q <= col_q + 2'h1;
    end
  end

  // Next state, output character and ready
  always @* begin
    state_d   = state_q;
    fcsCnt_d  = fcsCnt_q;
    fcsOn_d   = fcsOn_q;
    txData_d  = `ETXPC_CH_IDLE;
    txCtrl_d  = 1'b1;
    inReady_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // New frames start only when enabled and nothing forced
        if (!forced && ctrl_q[`ETXPC_CTRL_ENABLE] && inValid) begin
          state_d = ST_START;
          fcsOn_d = ctrl_q[`ETXPC_CTRL_FCS];
        end
      end
      ST_START: begin
        txData_d  = `ETXPC_CH_START;
        state_d   = ST_DATA;
        inReady_d = 1'b1;
      end
      ST_DATA: begin
        inReady_d = 1'b1;
        if (accept) begin
          // Enable is not looked at here: frame completes unless forcing drops it
          txData_d = inData;
          txCtrl_d = 1'b0;
          if (inLast) begin
            inReady_d = 1'b0;
            fcsCnt_d  = 2'h0;
            state_d   = fcsOn_q ? ST_FCS : ST_TERM;
          end
        end else begin
          // Source starved mid frame; mark the gap as an error
          txData_d = `ETXPC_CH_ERROR;
        end
      end
      ST_FCS: begin
        txCtrl_d = 1'b0;
        case (fcsCnt_q)
          2'h0:    txData_d = fcsWord[7:0];
          2'h1:    txData_d = fcsWord[15:8];
          2'h2:    txData_d = fcsWord[23:16];
          default: txData_d = fcsWord[31:24];
        endcase
        fcsCnt_d = fcsCnt_q + 2'h1;
        if (fcsCnt_q == `ETXPC_FCS_LAST) begin
          state_d = ST_TERM;
        end
      end
      ST_TERM: begin
        txData_d = `ETXPC_CH_TERM;
        state_d  = ST_IDLE;
      end
      ST_DROP: begin
        // Swallow the rest of the preempted frame
        inReady_d = 1'b1;
        if (accept && inLast) begin
          inReady_d = 1'b0;
          state_d   = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Forcing replaces every character; a frame in flight is dropped
    if (forced) begin
      if (state_q == ST_START || state_q == ST_DATA) begin
        state_d   = (accept && inLast) ? ST_IDLE : ST_DROP;
        inReady_d = !(accept && inLast);
      end else if (state_q == ST_FCS || state_q == ST_TERM) begin
        state_d = ST_IDLE;
      end
      if (forceLf || forceRf) begin
        // Local beats remote, both beat idle
        txCtrl_d = (col_q == `ETXPC_COL_SEQ);
        if (col_q == `ETXPC_COL_SEQ) begin
          txData_d = `ETXPC_CH_SEQ;
        end else if (col_q == `ETXPC_COL_CODE) begin
          txData_d = forceLf ? `ETXPC_CH_LF : `ETXPC_CH_RF;
        end else begin
          txData_d = `ETXPC_CH_ZERO;
        end
      end else begin
        txData_d = `ETXPC_CH_IDLE;
        txCtrl_d = 1'b1;
      end
    end
  end

  // State and registered link outputs; idle is the quiet default
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      fcsCnt_q <= 2'h0;
      fcsOn_q  <= 1'b0;
      txData   <= `ETXPC_CH_IDLE;
      txCtrl   <= 1'b1;
      inReady  <= 1'b0;
    end else if (ce) begin
      state_q  <= state_d;
      fcsCnt_q <= fcsCnt_d;
      fcsOn_q  <= fcsOn_d;
      txData   <= txData_d;
      txCtrl   <= txCtrl_d;
      inReady  <= inReady_d;
    end
  end

endmodule

// [verif/etxpc_link_rx.sv]
// Link partner receiver: frame length and CRC residue
`timescale 1ns/1ns
module etxpc_link_rx (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Link characters
  input  wire [7:0]  txData,
  input  wire        txCtrl,
  // Last frame seen
  output reg         frameDone,
  output reg  [7:0]  frameLen,
  output reg  [31:0] frameRes
);
  reg        openQ; // Inside a frame
  reg [31:0] crc;   // Running remainder, no final inversion
  // One byte folded into a reflected remainder, LSB first
  function [31:0] crcStep(input [31:0] c, input [7:0] d);
    integer i;
    begin
      crcStep = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1)
        crcStep = crcStep[0] ? (crcStep >> 1) ^ 32'hEDB88320 :
          crcStep >> 1;
    end
  endfunction
  // Residue over data plus a good FCS is a fixed constant
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      openQ     <= 1'b0;
      frameDone <= 1'b0;
      frameLen  <= 8'h00;
      frameRes  <= 32'h00000000;
      crc       <= 32'hFFFFFFFF;
    end else begin
      frameDone <= openQ && txCtrl && txData == 8'hFD;
      if (txCtrl) begin
        openQ    <= txData == 8'hFB;
        frameRes <= crc;
        if (txData == 8'hFB) begin
          frameLen <= 8'h00;
          crc      <= 32'hFFFFFFFF;
        end
      end else if (openQ) begin
        frameLen <= frameLen + 8'h01;
        crc      <= crcStep(crc, txData);
      end
    end
  end
endmodule

// [verif/etxpc_tx_monitor.sv]
// Port checker for the transmit path control block
`timescale 1ns/1ns
module etxpc_tx_monitor (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  input wire       ce,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdData,
  // Stream side
  input wire       inReady,
  input wire [7:0] txData,
  input wire       txCtrl,
  input wire       rateSel40g
);
  reg  [5:0] ctrlQ;   // Shadow of CTRL
  reg  [5:0] ctrlP1Q; // CTRL one cycle back
  reg        en2Q;    // Enable two cycles back
  reg        frameQ;  // Link shows an open frame
  // Forcing lags a write, so only settled settings are judged
  wire [5:0] anyS = ctrlQ | ctrlP1Q;
  wire [5:0] allS = ctrlQ & ctrlP1Q;
  wire       dis  = ~(anyS[0] | en2Q) & ~|anyS[3:1];
  // Track CTRL writes and frame framing on the link
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlQ   <= 6'h00;
      ctrlP1Q <= 6'h00;
      en2Q    <= 1'b0;
      frameQ  <= 1'b0;
    end else if (ce) begin
      // The block is frozen while ce is low, so is the shadow
      if (regWr && regAddr == 8'h00)
        ctrlQ <= regWrData[5:0];
      ctrlP1Q <= ctrlQ;
      en2Q    <= ctrlP1Q[0];
      // A start char opens a frame, an error char keeps it open, other control chars close it
      if (txCtrl)
        frameQ <= txData == 8'hFB || (frameQ && txData == 8'hFE);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rate_follow:
    assert property (ce && regWr && regAddr == 8'h00 |-> ##2
      rateSel40g == $past(regWrData[5], 2)) else $error("bad rate");
  a_local_codes:
    assert property (allS[2] |-> (txCtrl ? txData == 8'h9C :
      txData < 8'h02)) else $error("bad local fault");
  a_remote_codes:
    assert property (allS[1] && !anyS[2] |-> (txCtrl ? txData == 8'h9C
      : (txData & 8'hFD) == 8'h00)) else $error("bad remote fault");
  a_idle_codes:
    assert property (allS[3] && !anyS[2] && !anyS[1] |-> txCtrl &&
      txData == 8'h07) else $error("bad forced idle");
  a_disabled_idle:
    assert property (dis && !frameQ |-> txCtrl && txData == 8'h07)
    else $error("not idle while disabled");
  a_ready_frame:
    assert property (inReady |-> frameQ || |anyS[3:1] ||
      (txCtrl && txData == 8'hFB)) else $error("byte taken outside frame");
  a_read_ctrl:
    assert property (ce && regRd && regAddr == 8'h00 |=>
      regRdData == {2'b00, ctrlQ}) else $error("bad CTRL read");
  a_read_unmapped:
    assert property (ce && regRd && regAddr != 8'h00 && regAddr != 8'h04 |=>
      regRdData == 8'h00) else $error("bad unmapped read");
endmodule
bind etxpc_tx_ctrl etxpc_tx_monitor etxpc_tx_monitor_inst (.clk, .rst, .ce,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .inReady, .txData,
  .txCtrl, .rateSel40g);

// [verif/tb_eth_tx_path_control.sv]
// Self-checking bench for the transmit path control block
`timescale 1ns/1ns
module tb_eth_tx_path_control;
  reg         clk, rst, ce, regWr, regRd, inValid, inLast;
  reg  [7:0]  regAddr, regWrData, inData, v;
  wire [7:0]  regRdData, txData, frameLen;
  wire        inReady, txCtrl, rateSel40g, frameDone;
  wire [31:0] frameRes;
  integer     n_fail, comparisons, r;
  reg  [23:0] rows [0:3]; // CTRL, bytes sent, bytes on link
  etxpc_tx_ctrl etxpc_tx_ctrl_inst (.clk, .rst, .ce, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .inData, .inValid, .inLast, .inReady,
    .txData, .txCtrl, .rateSel40g);
  etxpc_link_rx etxpc_link_rx_inst (.clk, .rst, .txData, .txCtrl,
    .frameDone, .frameLen, .frameRes);
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      @(negedge clk);
      v = regRdData;
    end
  endtask
  task send(input [7:0] n);
    integer k;
    begin
      k = 0;
      @(posedge clk);
      inValid <= 1'b1;
      inData  <= 8'hA0;
      inLast  <= n == 8'h01;
      while (k < n) begin
        @(posedge clk);
        if (inReady === 1'b1) begin
          k = k + 1;
          inData  <= 8'hA0 + k[7:0];
          inLast  <= k + 1 == n;
          inValid <= k < n;
        end
      end
    end
  endtask
  // Bounded wait for the terminate char
  task done_wait;
    integer t;
    begin
      for (t = 0; t < 40 && frameDone !== 1'b1; t = t + 1)
        @(posedge clk);
      chk(frameDone, 1'b1);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_fail = n_fail + 1;
    final_report;
  end
  initial begin
    rows[0] = {8'h11, 8'h01, 8'h05};
    rows[1] = {8'h01, 8'h03, 8'h03};
    rows[2] = {8'h31, 8'h02, 8'h06};
    rows[3] = {8'h21, 8'h04, 8'h04};
    n_fail = 0;
    comparisons = 0;
    {rst, ce, regWr, regRd, inValid, inLast} = 6'h30;
    {regAddr, regWrData, inData} = 24'h000000;
    repeat (2) @(posedge clk);
    chk({inReady, txCtrl, txData}, {2'b01, 8'h07});
    for (r = 0; r < 4; r = r + 1) begin
      // Settings change only across a reset
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      wr(8'h00, rows[r][23:16]);
      send(rows[r][15:8]);
      done_wait;
      chk(frameLen, rows[r][7:0]);
      if (rows[r][20]) chk(frameRes, 32'hDEBB20E3);
      chk(rateSel40g, rows[r][21]);
      rd(8'h00);
      chk(v, rows[r][23:16]);
    end
    // FCS setting may only change across a reset
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    // Enable drops mid frame; the frame still ends whole
    wr(8'h00, 8'h11);
    fork
      send(8'h06);
      begin
        repeat (3) @(posedge clk);
        wr(8'h00, 8'h10);
      end
    join
    done_wait;
    chk(frameLen, 8'h0A);
    chk(frameRes, 32'hDEBB20E3);
    inValid <= 1'b1;
    repeat (10) @(posedge clk);
    chk(inReady, 1'b0);
    inValid <= 1'b0;
    // Partner not aligned: both faults forced with enable low, then remote fault with enable high
    wr(8'h00, 8'h16);
    repeat (8) @(posedge clk);
    rd(8'h04);
    chk(v, 8'h18);
    wr(8'h00, 8'h13);
    repeat (8) @(posedge clk);
    // Partner sends remote fault, so only idles leave
    wr(8'h00, 8'h19);
    inValid <= 1'b1;
    repeat (8) @(posedge clk);
    chk(inReady, 1'b0);
    inValid <= 1'b0;
    // Forcing cuts a frame; the rest of its bytes are still swallowed
    wr(8'h00, 8'h11);
    fork
      send(8'h06);
      begin
        repeat (3) @(posedge clk);
        wr(8'h00, 8'h15);
      end
    join
    rd(8'h04);
    chk(v, 8'h18);
    // Clock enable low: a write in that time is ignored
    ce <= 1'b0;
    wr(8'h00, 8'h01);
    ce <= 1'b1;
    rd(8'h00);
    chk(v, 8'h15);
    rd(8'h08);
    chk(v, 8'h00);
    final_report;
  end
endmodule
